// ==== core/pif_pkg.sv ====
/*
 * Constants, register map and address decode for the PHY interrupt flags.
 * Assumes a 32-bit AXI4-Lite bus with byte addresses four times the index.
 */
package pif_pkg;
   // ****************************************************************
   // Widths and register map.
   // ****************************************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int REG_W  = 16;
   localparam int LVL_N  = 4;

   localparam logic [ADDR_W-3:0] SRC_IDX = 6'h1D;
   localparam logic [ADDR_W-3:0] MSK_IDX = 6'h1E;
   localparam logic [ADDR_W-3:0] IST_IDX = 6'h20;
   localparam logic [ADDR_W-3:0] IMK_IDX = 6'h21;

   localparam logic [REG_W-1:0] REG_RST   = 16'h0000;
   localparam logic [REG_W-1:0] SRC_VALID = 16'h03FE;

   localparam int LINK_UP_BIT  = 9;
   localparam int WAKE_BIT     = 8;
   localparam int ENERGY_BIT   = 7;
   localparam int ANEG_BIT     = 6;
   localparam int RFAULT_BIT   = 5;
   localparam int LINK_DN_BIT  = 4;
   localparam int ACK_BIT      = 3;
   localparam int PDF_BIT      = 2;
   localparam int PAGE_BIT     = 1;

   localparam int LVL_LINK   = 0;
   localparam int LVL_ENERGY = 1;
   localparam int LVL_ANEG   = 2;
   localparam int LVL_RFAULT = 3;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PIF_SEL_NONE = 3'h0,
      PIF_SEL_SRC  = 3'h1,
      PIF_SEL_MSK  = 3'h3,
      PIF_SEL_IST  = 3'h2,
      PIF_SEL_IMK  = 3'h6
   } pif_sel_e;

   // Maps a byte address to the register it selects.
   function automatic pif_sel_e pif_decode(input logic [ADDR_W-1:0] a);
      pif_sel_e sel;
      sel = PIF_SEL_NONE;
      case (a[ADDR_W-1:2])
         SRC_IDX: sel = PIF_SEL_SRC;
         MSK_IDX: sel = PIF_SEL_MSK;
         IST_IDX: sel = PIF_SEL_IST;
         IMK_IDX: sel = PIF_SEL_IMK;
         default: sel = PIF_SEL_NONE;
      endcase
      return sel;
   endfunction : pif_decode
endpackage : pif_pkg

// ==== core/pif_edge_det.sv ====
/*
 * Rising and falling edge detector for a group of status levels.
 * Assumes levels synchronous to aclk.
 */
`timescale 1ns/1ps
module pif_edge_det #(
   parameter int N = 4
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [N-1:0] level,
   output logic      [N-1:0] rise,
   output logic      [N-1:0] fall
);
   typedef struct packed {
      logic [N-1:0] prev;
   } pif_edge_s;

   pif_edge_s s;
   pif_edge_s n;

   always_comb begin
      n      = s;
      n.prev = level;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   for (genvar i = 0; i < N; i++) begin : g_edge
      assign rise[i] = level[i] & ~s.prev[i];
      assign fall[i] = ~level[i] & s.prev[i];
   end
endmodule : pif_edge_det

// ==== core/pif_axil_port.sv ====
/*
 * AXI4-Lite slave handshake for the PHY interrupt flags registers.
 * Assumes the register file answers rd_data, rd_ok and wr_ok at once.
 */
`timescale 1ns/1ps
module pif_axil_port (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [pif_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [pif_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [pif_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [pif_pkg::DATA_W-1:0]     s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic                           wr_en,
   output logic [pif_pkg::ADDR_W-1:0]     wr_addr,
   output logic [pif_pkg::DATA_W-1:0]     wr_data,
   output logic [3:0]                     wr_strb,
   input  wire logic                      wr_ok,
   output logic                           rd_en,
   output logic [pif_pkg::ADDR_W-1:0]     rd_addr,
   input  wire logic [pif_pkg::DATA_W-1:0] rd_data,
   input  wire logic                      rd_ok
);
   typedef struct packed {
      logic                       aw_got;
      logic                       w_got;
      logic [pif_pkg::ADDR_W-1:0] awaddr;
      logic [pif_pkg::DATA_W-1:0] wdata;
      logic [3:0]                 wstrb;
      logic                       bvalid;
      logic [1:0]                 bresp;
      logic                       ar_got;
      logic [pif_pkg::ADDR_W-1:0] araddr;
      logic                       rvalid;
      logic [pif_pkg::DATA_W-1:0] rdata;
      logic [1:0]                 rresp;
   } pif_port_s;

   pif_port_s s;
   pif_port_s n;

   assign s_axi_awready = !s.aw_got && !s.bvalid;
   assign s_axi_wready  = !s.w_got && !s.bvalid;
   assign s_axi_arready = !s.ar_got && !s.rvalid;
   assign s_axi_bvalid  = s.bvalid;
   assign s_axi_bresp   = s.bresp;
   assign s_axi_rvalid  = s.rvalid;
   assign s_axi_rdata   = s.rdata;
   assign s_axi_rresp   = s.rresp;
   assign wr_en         = s.aw_got && s.w_got && !s.bvalid;
   assign wr_addr       = s.awaddr;
   assign wr_data       = s.wdata;
   assign wr_strb       = s.wstrb;
   assign rd_en         = s.ar_got && !s.rvalid;
   assign rd_addr       = s.araddr;

   always_comb begin
      n = s;
      if (s_axi_awvalid && s_axi_awready) begin
         n.aw_got = 1'b1;
         n.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (wr_en) begin
         n.bvalid = 1'b1;
         n.bresp  = wr_ok ? pif_pkg::RESP_OKAY : pif_pkg::RESP_SLVERR;
         n.aw_got = 1'b0;
         n.w_got  = 1'b0;
      end
      if (s.bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         n.ar_got = 1'b1;
         n.araddr = s_axi_araddr;
      end
      if (rd_en) begin
         n.rvalid = 1'b1;
         n.rdata  = rd_data;
         n.rresp  = rd_ok ? pif_pkg::RESP_OKAY : pif_pkg::RESP_SLVERR;
         n.ar_got = 1'b0;
      end
      if (s.rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end
endmodule : pif_axil_port

// ==== core/pif_phy_irq_flags.sv ====
/*
 * PHY interrupt flags: latched event flags, their enables, an interrupt
 * status and mask pair and the AXI4-Lite register file.
 * Assumes event inputs synchronous to aclk; pulses last one cycle.
 */
// Behaviour
// - A flag latches to one on its event while its enable is set and stays.
// - A read of the flag register returns the flags and then clears them.
// - Enable bits 9 to 1 mask at zero, enable at one; all reset to zero.
// - Enable bits match flag bits; bits 15:10 and 0 are read-only zero.
// - Bit 9 sets when link status rises.
// - Bit 8 sets on a wake event.
// - Bit 7 sets when line energy present becomes set.
// - Bit 6 sets when auto-negotiation completes.
// - Bit 5 sets when a remote fault is detected.
// - Bit 4 sets when link status falls.
// - Bit 3 sets on a link partner acknowledge.
// - Bit 2 sets on a parallel detection fault.
// - Bit 1 sets when a page is received.
`timescale 1ns/1ps
module pif_phy_irq_flags (
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   input  wire logic [pif_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [pif_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [pif_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [pif_pkg::DATA_W-1:0]     s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      link_status,
   input  wire logic                      line_energy_present,
   input  wire logic                      autoneg_complete,
   input  wire logic                      remote_fault,
   input  wire logic                      wake_event,
   input  wire logic                      partner_ack,
   input  wire logic                      parallel_detect_fault,
   input  wire logic                      page_received,
   output logic                           phy_irq_req,
   output logic                           irq
);
   // ****************************************************************
   // State and wiring.
   // ****************************************************************
   typedef struct packed {
      logic [pif_pkg::REG_W-1:0] flags;
      logic [pif_pkg::REG_W-1:0] enables;
      logic [pif_pkg::REG_W-1:0] ist;
      logic [pif_pkg::REG_W-1:0] imk;
   } pif_state_s;

   pif_state_s                 s;
   pif_state_s                 n;
   logic                       wr_en;
   logic [pif_pkg::ADDR_W-1:0] wr_addr;
   logic [pif_pkg::DATA_W-1:0] wr_data;
   logic [3:0]                 wr_strb;
   logic                       wr_ok;
   logic                       rd_en;
   logic [pif_pkg::ADDR_W-1:0] rd_addr;
   logic [pif_pkg::DATA_W-1:0] rd_data;
   logic                       rd_ok;
   pif_pkg::pif_sel_e          wr_sel;
   pif_pkg::pif_sel_e          rd_sel;
   logic [pif_pkg::LVL_N-1:0]  lvl;
   logic [pif_pkg::LVL_N-1:0]  rise;
   logic [pif_pkg::LVL_N-1:0]  fall;
   logic [pif_pkg::REG_W-1:0]  ev;
   logic [pif_pkg::REG_W-1:0]  latch;
   logic [pif_pkg::REG_W-1:0]  wmask;
   logic [pif_pkg::REG_W-1:0]  wval;
   logic [pif_pkg::REG_W-1:0]  src_clr;
   logic [pif_pkg::REG_W-1:0]  ist_clr;
   logic [pif_pkg::REG_W-1:0]  rd_val;
   logic                       src_rd;

   // ****************************************************************
   // Bus port and edge detection.
   // ****************************************************************
   pif_axil_port u_port (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_ok         (wr_ok),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_ok         (rd_ok)
   );

   assign lvl[pif_pkg::LVL_LINK]   = link_status;
   assign lvl[pif_pkg::LVL_ENERGY] = line_energy_present;
   assign lvl[pif_pkg::LVL_ANEG]   = autoneg_complete;
   assign lvl[pif_pkg::LVL_RFAULT] = remote_fault;

   pif_edge_det #(
      .N (pif_pkg::LVL_N)
   ) u_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .level   (lvl),
      .rise    (rise),
      .fall    (fall)
   );

   // ****************************************************************
   // Event vector and decode.
   // ****************************************************************
   always_comb begin
      ev                        = '0;
      ev[pif_pkg::LINK_UP_BIT]  = rise[pif_pkg::LVL_LINK];
      ev[pif_pkg::WAKE_BIT]     = wake_event;
      ev[pif_pkg::ENERGY_BIT]   = rise[pif_pkg::LVL_ENERGY];
      ev[pif_pkg::ANEG_BIT]     = rise[pif_pkg::LVL_ANEG];
      ev[pif_pkg::RFAULT_BIT]   = rise[pif_pkg::LVL_RFAULT];
      ev[pif_pkg::LINK_DN_BIT]  = fall[pif_pkg::LVL_LINK];
      ev[pif_pkg::ACK_BIT]      = partner_ack;
      ev[pif_pkg::PDF_BIT]      = parallel_detect_fault;
      ev[pif_pkg::PAGE_BIT]     = page_received;
   end

   assign wr_sel = pif_pkg::pif_decode(wr_addr);
   assign rd_sel = pif_pkg::pif_decode(rd_addr);
   assign wr_ok  = (wr_sel != pif_pkg::PIF_SEL_NONE);
   assign rd_ok  = (rd_sel != pif_pkg::PIF_SEL_NONE);
   assign src_rd = rd_en && (rd_sel == pif_pkg::PIF_SEL_SRC);
   assign wmask  = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   assign wval   = wr_data[pif_pkg::REG_W-1:0];

   // Latch only enabled, implemented sources.
   assign latch   = ev & s.enables & pif_pkg::SRC_VALID;
   assign src_clr = src_rd ? pif_pkg::SRC_VALID : '0;
   assign ist_clr = (wr_en && wr_sel == pif_pkg::PIF_SEL_IST) ?
                    (wval & wmask) : '0;

   // ****************************************************************
   // Register file.
   // ****************************************************************
   always_comb begin
      n = s;
      // A set in the clearing cycle wins over the clear.
      n.flags = (s.flags & ~src_clr) | latch;
      n.ist   = (s.ist & ~ist_clr) | latch;
      if (wr_en && wr_sel == pif_pkg::PIF_SEL_MSK) begin
         n.enables = (s.enables & ~wmask) |
                     (wval & wmask & pif_pkg::SRC_VALID);
      end
      if (wr_en && wr_sel == pif_pkg::PIF_SEL_IMK) begin
         n.imk = (s.imk & ~wmask) | (wval & wmask & pif_pkg::SRC_VALID);
      end
   end

   always_comb begin
      case (rd_sel)
         pif_pkg::PIF_SEL_SRC: rd_val = s.flags;
         pif_pkg::PIF_SEL_MSK: rd_val = s.enables;
         pif_pkg::PIF_SEL_IST: rd_val = s.ist;
         pif_pkg::PIF_SEL_IMK: rd_val = s.imk;
         default:              rd_val = '0;
      endcase
   end

   assign rd_data = {{(pif_pkg::DATA_W-pif_pkg::REG_W){1'b0}}, rd_val};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s.flags   <= pif_pkg::REG_RST;
         s.enables <= pif_pkg::REG_RST;
         s.ist     <= pif_pkg::REG_RST;
         s.imk     <= pif_pkg::REG_RST;
      end else begin
         s <= n;
      end
   end

   assign phy_irq_req = |s.flags;
   assign irq         = |(s.ist & s.imk);

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_flag_latch: assert property ((latch != '0) |=>
      ((s.flags & $past(latch)) == $past(latch)))
      else $error("enabled event did not latch its flag");

   a_flag_hold: assert property (!src_rd |=>
      ((s.flags & $past(s.flags)) == $past(s.flags)))
      else $error("flag dropped without a read");

   a_read_clear: assert property ((src_rd && latch == '0) |=>
      (s.flags == '0) ##0 !phy_irq_req)
      else $error("flag read did not clear the flags");

   a_read_data: assert property (src_rd |=>
      (s_axi_rvalid && s_axi_rdata == {{(pif_pkg::DATA_W -
       pif_pkg::REG_W){1'b0}}, $past(s.flags)}))
      else $error("flag read returned wrong data");

   a_masked_quiet: assert property (
      (s.flags & ~$past(s.flags) & ~$past(s.enables)) == '0)
      else $error("flag set while its source was masked");

   a_mask_write: assert property (
      (wr_en && wr_sel == pif_pkg::PIF_SEL_MSK && wr_strb[1:0] == 2'h3)
      |=> (s.enables == ($past(wval) & pif_pkg::SRC_VALID)))
      else $error("enable write not stored");

   a_reserved_zero: assert property (
      ((s.flags | s.enables) & ~pif_pkg::SRC_VALID) == '0)
      else $error("reserved bit set");

   a_link_up: assert property (
      ($rose(link_status) && s.enables[pif_pkg::LINK_UP_BIT])
      |=> s.flags[pif_pkg::LINK_UP_BIT])
      else $error("link up did not set its flag");

   a_link_down: assert property (
      ($fell(link_status) && s.enables[pif_pkg::LINK_DN_BIT])
      |=> s.flags[pif_pkg::LINK_DN_BIT])
      else $error("link down did not set its flag");

   a_wake_flag: assert property (
      (wake_event && s.enables[pif_pkg::WAKE_BIT])
      |=> s.flags[pif_pkg::WAKE_BIT])
      else $error("wake event did not set its flag");

   a_req_level: assert property ((latch != '0) |=> phy_irq_req)
      else $error("request low with a flag latched");
endmodule : pif_phy_irq_flags

// ==== bench/tb_pif_phy_irq_flags.sv ====
/*
 * Self-checking bench for the PHY interrupt flags block.
 * Assumes pif_pkg and the core modules are compiled before this file.
 */
`timescale 1ns/1ps
module tb_pif_phy_irq_flags;
   // ****************************************************************
   // Signals and model state.
   // ****************************************************************
   logic        aclk;
   logic        aresetn;
   logic [7:0]  s_axi_awaddr;
   logic        s_axi_awvalid;
   logic        s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0]  s_axi_wstrb;
   logic        s_axi_wvalid;
   logic        s_axi_wready;
   logic [1:0]  s_axi_bresp;
   logic        s_axi_bvalid;
   logic        s_axi_bready;
   logic [7:0]  s_axi_araddr;
   logic        s_axi_arvalid;
   logic        s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0]  s_axi_rresp;
   logic        s_axi_rvalid;
   logic        s_axi_rready;
   logic [7:0]  ev_in;
   logic        phy_irq_req;
   logic        irq;
   logic [15:0] m_flag;
   logic [15:0] m_en;
   logic [15:0] m_stat;
   logic [15:0] m_imsk;
   logic [7:0]  prv;
   int          fails;
   int          total_checks;
   int          k;
   logic [15:0] fire_exp [8] = '{16'h0210, 16'h0080, 16'h0040, 16'h0020,
                                 16'h0100, 16'h0008, 16'h0004, 16'h0002};

   pif_phy_irq_flags i_pif_phy_irq_flags (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .link_status(ev_in[0]), .line_energy_present(ev_in[1]),
      .autoneg_complete(ev_in[2]), .remote_fault(ev_in[3]),
      .wake_event(ev_in[4]), .partner_ack(ev_in[5]),
      .parallel_detect_fault(ev_in[6]), .page_received(ev_in[7]),
      .phy_irq_req(phy_irq_req), .irq(irq)
   );

   // ****************************************************************
   // Helpers.
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string msg);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: %s got %h want %h", $time, msg, got,
                  exp);
      end
   endtask : chk

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : close_out

   // Events seen when inputs move from p to c.
   function automatic logic [15:0] evs(input logic [7:0] p,
                                       input logic [7:0] c);
      logic [15:0] e;
      e = 16'h0000;
      e[9] = ~p[0] & c[0];
      e[4] = p[0] & ~c[0];
      e[7] = ~p[1] & c[1];
      e[6] = ~p[2] & c[2];
      e[5] = ~p[3] & c[3];
      e[8] = c[4];
      e[3] = c[5];
      e[2] = c[6];
      e[1] = c[7];
      return e;
   endfunction : evs

   task automatic drv(input logic [7:0] v);
      logic [15:0] e;
      @(posedge aclk);
      ev_in <= v;
      e = evs(prv, v) & m_en;
      m_flag |= e;
      m_stat |= e;
      prv = v;
   endtask : drv

   task automatic irq_chk;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk({31'h0, phy_irq_req}, {31'h0, |m_flag}, "request");
      chk({31'h0, irq}, {31'h0, |(m_stat & m_imsk)}, "irq");
   endtask : irq_chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      logic ta, tw, aw, w, tb;
      logic [1:0]  r;
      logic [1:0]  er;
      logic [15:0] bm;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'h1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= s;
      s_axi_wvalid  <= 1'h1;
      s_axi_bready  <= 1'h1;
      aw = 1'h1;
      w = 1'h1;
      while (aw || w) begin
         @(negedge aclk);
         ta = s_axi_awready;
         tw = s_axi_wready;
         @(posedge aclk);
         if (aw && ta) begin
            aw = 1'h0;
            s_axi_awvalid <= 1'h0;
         end
         if (w && tw) begin
            w = 1'h0;
            s_axi_wvalid <= 1'h0;
         end
      end
      tb = 1'h0;
      while (!tb) begin
         @(negedge aclk);
         tb = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge aclk);
      end
      s_axi_bready <= 1'h0;
      bm = {{8{s[1]}}, {8{s[0]}}};
      er = pif_pkg::RESP_OKAY;
      case (a)
         8'h74: er = pif_pkg::RESP_OKAY;
         8'h78: m_en = ((m_en & ~bm) | (d[15:0] & bm)) & 16'h03FE;
         8'h80: m_stat &= ~(d[15:0] & bm);
         8'h84: m_imsk = ((m_imsk & ~bm) | (d[15:0] & bm)) & 16'h03FE;
         default: er = pif_pkg::RESP_SLVERR;
      endcase
      chk({30'h0, r}, {30'h0, er}, "bresp");
   endtask : wr

   task automatic rd(input logic [7:0] a);
      logic ta, tr;
      logic [31:0] d;
      logic [31:0] ed;
      logic [1:0]  r;
      logic [1:0]  er;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready  <= 1'h1;
      ta = 1'h0;
      while (!ta) begin
         @(negedge aclk);
         ta = s_axi_arready;
         @(posedge aclk);
      end
      s_axi_arvalid <= 1'h0;
      tr = 1'h0;
      while (!tr) begin
         @(negedge aclk);
         tr = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge aclk);
      end
      s_axi_rready <= 1'h0;
      er = pif_pkg::RESP_OKAY;
      ed = 32'h0000_0000;
      case (a)
         8'h74: begin
            ed = {16'h0000, m_flag};
            m_flag = 16'h0000;
         end
         8'h78: ed = {16'h0000, m_en};
         8'h80: ed = {16'h0000, m_stat};
         8'h84: ed = {16'h0000, m_imsk};
         default: er = pif_pkg::RESP_SLVERR;
      endcase
      chk(d, ed, "rdata");
      chk({30'h0, r}, {30'h0, er}, "rresp");
   endtask : rd

   // ****************************************************************
   // Clock, watchdog and test sequence.
   // ****************************************************************
   initial begin
      aclk = 1'h0;
      forever #20 aclk = ~aclk;
   end

   initial begin
      repeat (30000) @(posedge aclk);
      fails++;
      close_out();
   end

   initial begin
      void'($urandom(32'h7522));
      aresetn = 1'h0;
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
      {s_axi_arvalid, s_axi_rready, ev_in, prv} = '0;
      {m_flag, m_en, m_stat, m_imsk} = '0;
      fails = 0;
      total_checks = 0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'h1;
      irq_chk();
      rd(8'h74);
      rd(8'h78);
      rd(8'h80);
      rd(8'h84);
      wr(8'h78, 32'hFFFF_FFFF, 4'h1);
      rd(8'h78);
      wr(8'h78, 32'hFFFF_FFFF, 4'hF);
      rd(8'h78);
      wr(8'h74, 32'h0000_FFFF, 4'hF);
      rd(8'h74);
      wr(8'h40, 32'h0000_FFFF, 4'hF);
      rd(8'h40);
      for (k = 0; k < 8; k++) begin
         wr(8'h78, 32'h0000_0000, 4'hF);
         drv(8'h01 << k);
         drv(8'h00);
         rd(8'h74);
         wr(8'h78, 32'h0000_03FE, 4'hF);
         wr(8'h84, 32'h0000_03FE, 4'hF);
         drv(8'h01 << k);
         drv(8'h00);
         chk({16'h0, m_flag}, {16'h0, fire_exp[k]}, "src");
         irq_chk();
         rd(8'h74);
         rd(8'h74);
         irq_chk();
         rd(8'h80);
         wr(8'h80, 32'h0000_FFFF, 4'hF);
         irq_chk();
      end
      repeat (20) begin
         wr(8'h78, $urandom, 4'hF);
         wr(8'h84, $urandom, 4'hF);
         repeat (10) drv(8'($urandom));
         drv(prv & 8'h0F);
         irq_chk();
         rd(8'h80);
         rd(8'h74);
         irq_chk();
         wr(8'h80, $urandom, 4'($urandom));
         irq_chk();
         rd(8'h80);
      end
      close_out();
   end
endmodule : tb_pif_phy_irq_flags
